// ---- rtl/itv_top.sv ----
// Interrupt vector assignment and hardware trap handling
`include "itv_consts.svh"
`default_nettype none
module itv_top
   import itv_pkg::*;
#(
   parameter int NSRC  = 36,
   parameter int SEG_W = 8,
   parameter int OFF_W = 16
)
(
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   // Register port
   input  wire logic [3:0]             reg_addr,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [15:0]            reg_rdata,
   // Peripheral request pulses
   input  wire logic [NSRC-1:0]        periph_req,
   // Hardware trap condition pulses
   input  wire logic [9:0]             hw_trap,
   // Software trap instruction
   input  wire logic                   sw_trap_req,
   input  wire logic [6:0]             sw_trap_num,
   output logic                        sw_trap_busy,
   // Vector presentation to the core
   output logic                        vec_valid,
   output logic      [SEG_W+OFF_W-1:0] vec_addr,
   output logic      [6:0]             vec_trap_num,
   input  wire logic                   vec_ack,
   input  wire logic                   svc_done,
   // Interrupt line
   output logic                        trap_irq
);

   localparam int NF = `ITV_NUM_FLAGS;
   localparam int NA = `ITV_NUM_A;
   localparam int NW = (NSRC + 15) / 16;

   ////////////////////////////////////////////////////////////////////////
   // Decoding functions
   // Trap number of a peripheral source
   function automatic logic [6:0] src_trap_num(input int idx);
      if (idx < `ITV_IDX_SYS_FIRST)
         src_trap_num = 7'(int'(`ITV_TN_CAN6) + idx);
      else
         src_trap_num = 7'(int'(`ITV_TN_SYS_EXT0) + idx
                           - `ITV_IDX_SYS_FIRST);
   endfunction

   // Register write strobe for one word address
   function automatic logic wr_hit(input logic [3:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State
   itv_state_t             state_q;
   itv_level_t             level_q;
   logic [SEG_W-1:0]       vseg_q;
   logic [1:0]             spacing_q;
   logic [NF-1:0]          tflag_q;
   logic [NF-1:0]          tmask_q;
   logic [NF-1:0]          serve_q;
   logic [NW*16-1:0]       en_q;
   logic [NSRC-1:0]        pend_q;
   logic [15:0]            rdata_q;
   logic                   vvalid_q;
   logic [SEG_W+OFF_W-1:0] vaddr_q;
   logic [6:0]             vnum_q;
   itv_level_t             plevel_q;
   logic [NF-1:0]          pserve_q;
   logic [NSRC-1:0]        psrc_q;

   ////////////////////////////////////////////////////////////////////////
   // Selection of the next vector
   logic                   sel_go;
   logic [6:0]             sel_num;
   itv_level_t             sel_level;
   logic [NF-1:0]          sel_serve;
   logic [NSRC-1:0]        sel_src;
   logic [NSRC-1:0]        ready_src;
   logic [SEG_W+OFF_W-1:0] sel_addr;
   logic                   take;
   logic                   acked;

   assign ready_src = pend_q & en_q[NSRC-1:0];
   assign acked     = vvalid_q && vec_ack;

   // Priority: class A, class B, software trap, lowest source
   always_comb
   begin
      sel_go    = 1'b0;
      sel_num   = `ITV_TN_RESET;
      sel_level = LV_NONE;
      sel_serve = '0;
      sel_src   = '0;
      if (state_q == ST_BOOT)
      begin
         sel_go = 1'b1;
      end
      else if (|serve_q[NA-1:0] && level_q != LV_TRAPA)
      begin
         sel_go    = 1'b1;
         sel_level = LV_TRAPA;
         for (int i = NA - 1; i >= 0; i--)
         begin
            if (serve_q[i])
            begin
               sel_num   = 7'(2 * (i + 1));
               sel_serve = NF'(1) << i;
            end
         end
      end
      else if (|serve_q[NF-1:NA] && level_q < LV_TRAPB)
      begin
         sel_go    = 1'b1;
         sel_level = LV_TRAPB;
         sel_num   = `ITV_TN_CLASS_B;
         sel_serve = serve_q & ~NF'((1 << NA) - 1);
      end
      else if (sw_trap_req)
      begin
         sel_go    = 1'b1;
         sel_level = level_q;
         sel_num   = sw_trap_num;
      end
      else if (|ready_src && level_q < LV_TRAPB)
      begin
         sel_go    = 1'b1;
         sel_level = LV_INT;
         for (int i = NSRC - 1; i >= 0; i--)
         begin
            if (ready_src[i])
            begin
               sel_num = src_trap_num(i);
               sel_src = NSRC'(1) << i;
            end
         end
      end
   end

   assign take = sel_go && (state_q != ST_PRESENT);

   // Vector address from segment and spacing
   itv_vec_calc
   #(
      .SEG_W    (SEG_W),
      .OFF_W    (OFF_W)
   )
   u_vec_calc
   (
      .seg      (vseg_q),
      .spacing  (spacing_q),
      .trap_num (sel_num),
      .addr     (sel_addr)
   );

   ////////////////////////////////////////////////////////////////////////
   // Presentation sequencer
   // Boot vector first, then one presentation at a time
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         state_q <= ST_BOOT;
      else
      begin
         case (state_q)
            ST_BOOT:
               state_q <= ST_PRESENT;
            ST_IDLE:
               if (take)
                  state_q <= ST_PRESENT;
            ST_PRESENT:
               if (acked)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Vector outputs held until the core accepts
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         vvalid_q <= 1'b0;
         vaddr_q  <= '0;
         vnum_q   <= `ITV_TN_RESET;
         plevel_q <= LV_NONE;
         pserve_q <= '0;
         psrc_q   <= '0;
      end
      else if (take)
      begin
         vvalid_q <= 1'b1;
         vaddr_q  <= sel_addr;
         vnum_q   <= sel_num;
         plevel_q <= sel_level;
         pserve_q <= sel_serve;
         psrc_q   <= sel_src;
      end
      else if (acked)
         vvalid_q <= 1'b0;
   end

   // Level of the service now running
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         level_q <= LV_NONE;
      else if (acked)
         level_q <= plevel_q;
      else if (svc_done)
         level_q <= LV_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // Trap flags and service requests
   // Flags: set wins over write-one-to-clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         tflag_q <= '0;
      else
         tflag_q <= (tflag_q & ~(wr_hit(`ITV_REG_TFLAG) ?
                     reg_wdata[NF-1:0] : NF'(0))) | hw_trap;
   end

   // Serve bits ignore the mask; dropped when their vector is taken
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         serve_q <= '0;
      else
         serve_q <= (serve_q & ~(acked ? pserve_q : NF'(0)))
                    | hw_trap;
   end

   ////////////////////////////////////////////////////////////////////////
   // Peripheral requests
   // Pending bit per source; new request wins over its acceptance
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         pend_q <= '0;
      else
         pend_q <= (pend_q & ~(acked ? psrc_q : NSRC'(0)))
                   | periph_req;
   end

   // Per-source enable words
   genvar w;
   generate
      for (w = 0; w < NW; w++)
      begin : g_en
         always_ff @(posedge ref_clk)
         begin
            if (!rst_b)
               en_q[w*16 +: 16] <= 16'h0000;
            else if (wr_hit(4'(int'(`ITV_REG_EN0) + w)))
               en_q[w*16 +: 16] <= reg_wdata;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   // Vector segment
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         vseg_q <= `ITV_VSEG_RST;
      else if (wr_hit(`ITV_REG_VSEG))
         vseg_q <= reg_wdata[SEG_W-1:0];
   end

   // Vector spacing field
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         spacing_q <= `ITV_SPACING_RST;
      else if (wr_hit(`ITV_REG_CPUCFG))
         spacing_q <= reg_wdata[1:0];
   end

   // Interrupt mask over the trap flags
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         tmask_q <= `ITV_TMASK_RST;
      else if (wr_hit(`ITV_REG_TMASK))
         tmask_q <= reg_wdata[NF-1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path
   logic [NW*16-1:0] pend_ext;
   logic [15:0]      rd_mux;

   assign pend_ext = (NW*16)'(pend_q);

   // Read data one cycle after the strobe
   always_comb
   begin
      rd_mux = 16'h0000;
      case (reg_addr)
         `ITV_REG_VSEG:   rd_mux = 16'(vseg_q);
         `ITV_REG_CPUCFG: rd_mux = 16'(spacing_q);
         `ITV_REG_TFLAG:  rd_mux = 16'(tflag_q);
         `ITV_REG_TMASK:  rd_mux = 16'(tmask_q);
         `ITV_REG_STATUS: rd_mux = {11'h000, vvalid_q, level_q, state_q};
         default:
         begin
            for (int i = 0; i < NW; i++)
            begin
               if (reg_addr == 4'(int'(`ITV_REG_EN0) + i))
                  rd_mux = en_q[i*16 +: 16];
               if (reg_addr == 4'(int'(`ITV_REG_PEND0) + i))
                  rd_mux = pend_ext[i*16 +: 16];
            end
         end
      endcase
   end

   // Read data register, zero outside the cycle after a read
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         rdata_q <= 16'h0000;
      else if (reg_rd)
         rdata_q <= rd_mux;
      else
         rdata_q <= 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata    = rdata_q;
   assign vec_valid    = vvalid_q;
   assign vec_addr     = vaddr_q;
   assign vec_trap_num = vnum_q;
   assign sw_trap_busy = (state_q != ST_IDLE) || |serve_q;
   assign trap_irq     = |(tflag_q & tmask_q);

endmodule
`default_nettype wire

// ---- rtl/itv_consts.svh ----
// Offsets, field positions, reset values and trap numbers of the block
`ifndef ITV_CONSTS_SVH
`define ITV_CONSTS_SVH

// Register word addresses
`define ITV_REG_VSEG      4'h0
`define ITV_REG_CPUCFG    4'h1
`define ITV_REG_TFLAG     4'h2
`define ITV_REG_TMASK     4'h3
`define ITV_REG_STATUS    4'h4
`define ITV_REG_EN0       4'h5
`define ITV_REG_PEND0     4'h8

// Reset values
`define ITV_VSEG_RST      8'h00
`define ITV_SPACING_RST   2'h0
`define ITV_TMASK_RST     10'h000

// Trap flag bit positions, class A then class B
`define ITV_F_SYSREQ0     0
`define ITV_F_STK_OVER    1
`define ITV_F_STK_UNDER   2
`define ITV_F_SOFT_BRK    3
`define ITV_F_SYSREQ1     4
`define ITV_F_MPROT       5
`define ITV_F_BAD_OPCODE  6
`define ITV_F_ACCERR      7
`define ITV_F_PROT_INSTR  8
`define ITV_F_ILLWORD     9
`define ITV_NUM_A         4
`define ITV_NUM_FLAGS     10

// Trap numbers
`define ITV_TN_RESET      7'h00
`define ITV_TN_CLASS_B    7'h0a
`define ITV_TN_CAN6       7'h46
`define ITV_TN_SYS_EXT0   7'h68
`define ITV_IDX_SYS_FIRST 28

// Byte shift for the default spacing of four bytes
`define ITV_SPACING_SHIFT 2

`endif

// ---- rtl/itv_pkg.sv ----
// Types shared by the trap and vector logic
`default_nettype none
package itv_pkg;

   typedef enum logic [1:0]
   {
      ST_BOOT    = 2'b00,
      ST_IDLE    = 2'b01,
      ST_PRESENT = 2'b10
   } itv_state_t;

   typedef enum logic [1:0]
   {
      LV_NONE  = 2'b00,
      LV_INT   = 2'b01,
      LV_TRAPB = 2'b10,
      LV_TRAPA = 2'b11
   } itv_level_t;

endpackage
`default_nettype wire

// ---- rtl/itv_vec_calc.sv ----
// Vector address from segment, spacing field and trap number
`include "itv_consts.svh"
`default_nettype none
module itv_vec_calc
#(
   parameter int SEG_W = 8,
   parameter int OFF_W = 16
)
(
   // Vector table placement
   input  wire logic [SEG_W-1:0]       seg,
   input  wire logic [1:0]             spacing,
   // Selected vector
   input  wire logic [6:0]             trap_num,
   output logic      [SEG_W+OFF_W-1:0] addr
);

   logic [OFF_W-1:0] offset;

   // Offset is trap number times the spacing, placed in the segment
   always_comb
   begin
      offset = OFF_W'(trap_num) << (`ITV_SPACING_SHIFT + int'(spacing));
      addr   = {seg, offset};
   end

endmodule
`default_nettype wire

// ---- bench/itv_top_assertions.sv ----
// Concurrent checks on the vector, trap and register ports
`default_nettype none
module itv_top_assertions
#(
   parameter int SEG_W = 8,
   parameter int OFF_W = 16
)
(
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   rst_b,
   // Register port
   input wire logic [3:0]             reg_addr,
   input wire logic                   reg_rd,
   input wire logic                   reg_wr,
   input wire logic [15:0]            reg_rdata,
   // Trap inputs
   input wire logic [9:0]             hw_trap,
   input wire logic                   sw_trap_req,
   input wire logic [6:0]             sw_trap_num,
   input wire logic                   sw_trap_busy,
   // Vector port
   input wire logic                   vec_valid,
   input wire logic [SEG_W+OFF_W-1:0] vec_addr,
   input wire logic [6:0]             vec_trap_num,
   input wire logic                   vec_ack,
   input wire logic                   trap_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Vector waiting, and vector taken by the core
   sequence s_waiting;
      vec_valid && !vec_ack;
   endsequence
   sequence s_taken;
      vec_valid && vec_ack;
   endsequence
   chk_vec_hold:
      assert property (s_waiting |=> vec_valid && $stable(vec_addr)
         && $stable(vec_trap_num)) else $error("vector moved before ack");
   chk_vec_drop:
      assert property (s_taken |=> !vec_valid)
      else $error("vector stayed after ack");
   chk_addr_step:
      assert property (vec_valid |-> vec_addr[1:0] == 2'h0 &&
         ((vec_addr[OFF_W-1:0] == '0) == (vec_trap_num == 7'h00)))
      else $error("vector offset not a trap number step");
   chk_sw_taken:
      assert property (sw_trap_req && !sw_trap_busy |=> vec_valid &&
         vec_trap_num == $past(sw_trap_num)) else $error("sw trap lost");
   chk_rdata_quiet:
      assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   chk_unmapped_zero:
      assert property (reg_rd && reg_addr > 4'ha |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_busy_present:
      assert property (vec_valid |-> sw_trap_busy)
      else $error("not busy while presenting");
   chk_irq_cause:
      assert property ($rose(trap_irq) |-> $past(hw_trap) != 10'h000 ||
         $past(reg_wr)) else $error("interrupt line rose without cause");
endmodule
bind itv_top itv_top_assertions #(.SEG_W(SEG_W), .OFF_W(OFF_W)) u_chk
(
   .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
   .hw_trap(hw_trap), .sw_trap_req(sw_trap_req),
   .sw_trap_num(sw_trap_num), .sw_trap_busy(sw_trap_busy),
   .vec_valid(vec_valid), .vec_addr(vec_addr),
   .vec_trap_num(vec_trap_num), .vec_ack(vec_ack), .trap_irq(trap_irq)
);
`default_nettype wire

// ---- bench/itv_core_model.sv ----
// Core model that accepts vectors and returns from services
`default_nettype none
module itv_core_model
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Vector handshake
   input  wire logic       vec_valid,
   output logic            vec_ack,
   output logic            svc_done,
   // Bench control
   input  wire logic [3:0] ack_wait,
   input  wire logic       done_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // Take a standing vector after ack_wait cycles, one-cycle pulse
   always_ff @(posedge ref_clk)
   begin
      vec_ack <= 1'b0;
      if (!rst_b)
         cnt <= 4'h0;
      else if (vec_valid && !vec_ack)
      begin
         if (cnt >= ack_wait)
         begin
            vec_ack <= 1'b1;
            cnt     <= 4'h0;
         end
         else
            cnt <= cnt + 4'h1;
      end
   end
   // Return from service one cycle after the bench asks
   always_ff @(posedge ref_clk)
      svc_done <= rst_b && done_req;
endmodule
`default_nettype wire

// ---- bench/tb_interrupt_trap_vectoring.sv ----
// Self-checking bench for the vector and trap block
`default_nettype none
module tb_interrupt_trap_vectoring;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [35:0] periph_req = '0;
   logic [9:0]  hw_trap = 10'h000;
   logic        sw_trap_req = 1'b0;
   logic [6:0]  sw_trap_num = 7'h00;
   logic [3:0]  ack_wait = 4'h0;
   logic        done_req = 1'b0;
   logic [7:0]  seg_e = 8'h00;
   logic [1:0]  sp_e = 2'h0;
   wire logic [15:0] reg_rdata;
   wire logic [23:0] vec_addr;
   wire logic [6:0]  vec_trap_num;
   wire logic        sw_trap_busy, vec_valid, vec_ack, svc_done, trap_irq;
   int          miscompares = 0;
   int          total_checks = 0;
   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   itv_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .periph_req(periph_req), .hw_trap(hw_trap),
      .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num),
      .sw_trap_busy(sw_trap_busy), .vec_valid(vec_valid),
      .vec_addr(vec_addr), .vec_trap_num(vec_trap_num),
      .vec_ack(vec_ack), .svc_done(svc_done), .trap_irq(trap_irq));
   itv_core_model u_core (.ref_clk(ref_clk), .rst_b(rst_b),
      .vec_valid(vec_valid), .vec_ack(vec_ack), .svc_done(svc_done),
      .ack_wait(ack_wait), .done_req(done_req));
   ////////////////////////////////////////
   // Compare, report and bus tasks
   task automatic chk(input string w, input logic [23:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", w, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
   endtask
   task automatic ev(input logic [9:0] h, input logic [35:0] p);
      @(posedge ref_clk);
      hw_trap <= h;
      periph_req <= p;
      @(posedge ref_clk);
      hw_trap <= 10'h000;
      periph_req <= '0;
   endtask
   task automatic sw(input logic [6:0] t);
      @(posedge ref_clk);
      sw_trap_req <= 1'b1;
      sw_trap_num <= t;
      @(posedge ref_clk);
      sw_trap_req <= 1'b0;
   endtask
   task automatic done();
      @(posedge ref_clk);
      done_req <= 1'b1;
      @(posedge ref_clk);
      done_req <= 1'b0;
   endtask
   task automatic wait_vec(input logic want);
      int k;
      k = 0;
      while (vec_valid !== want && k < 60)
      begin
         @(posedge ref_clk);
         #1 k++;
      end
      if (vec_valid !== want)
      begin
         miscompares++;
         $display("BAD vec_valid exp %b got %b", want, vec_valid);
         stop_test();
      end
   endtask
   task automatic expv(input logic [6:0] t);
      wait_vec(1'b1);
      chk("vec_trap_num", {17'h0, t}, {17'h0, vec_trap_num});
      chk("vec_addr", {seg_e, 16'(t) << (2 + sp_e)}, vec_addr);
      wait_vec(1'b0);
   endtask
   function automatic logic [6:0] src_num(input int s);
      if (s < 10)
         return 7'h46 + 7'(s);
      if (s < 28)
         return 7'h50 + 7'(s - 10);
      return 7'h68 + 7'(s - 28);
   endfunction
   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      expv(7'h00);
      done();
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'hf, 16'h0000);
      $display("test reset done");
      seg_e = 8'h12;
      wr(4'h0, 16'h0012);
      sw(7'h7f);
      expv(7'h7f);
      sp_e = 2'h1;
      ack_wait = 4'h5;
      wr(4'h1, 16'h0001);
      sw(7'h46);
      expv(7'h46);
      sp_e = 2'h3;
      wr(4'h1, 16'h0003);
      rd(4'h1, 16'h0003);
      sw(7'h7f);
      expv(7'h7f);
      sp_e = 2'h0;
      wr(4'h1, 16'h0000);
      $display("test segment and spacing done");
      ev(10'h000, 36'h1);
      rd(4'h8, 16'h0001);
      wr(4'h5, 16'hffff);
      expv(7'h46);
      done();
      wr(4'h6, 16'hffff);
      wr(4'h7, 16'h000f);
      for (int i = 0; i < 36; i++)
      begin
         ev(10'h000, 36'h1 << i);
         expv(src_num(i));
         done();
      end
      $display("test sources done");
      for (int i = 0; i < 4; i++)
      begin
         ev(10'h001 << i, '0);
         expv(7'(2 * i + 2));
         chk("trap_irq", 24'h0, {23'h0, trap_irq});
         done();
      end
      rd(4'h2, 16'h000f);
      wr(4'h2, 16'h000f);
      rd(4'h2, 16'h0000);
      wr(4'h3, 16'h03f0);
      ev(10'h3f0, '0);
      expv(7'h0a);
      chk("trap_irq", 24'h1, {23'h0, trap_irq});
      rd(4'h2, 16'h03f0);
      done();
      repeat (6) @(posedge ref_clk);
      #1 chk("vec_valid", 24'h0, {23'h0, vec_valid});
      wr(4'h2, 16'h03f0);
      rd(4'h2, 16'h0000);
      chk("trap_irq", 24'h0, {23'h0, trap_irq});
      $display("test hardware traps done");
      ack_wait = 4'h0;
      ev(10'h024, 36'h1 << 34);
      expv(7'h06);
      repeat (6) @(posedge ref_clk);
      #1 chk("vec_valid", 24'h0, {23'h0, vec_valid});
      chk("sw_trap_busy", 24'h1, {23'h0, sw_trap_busy});
      rd(4'h4, 16'h000d);
      rd(4'h2, 16'h0024);
      done();
      expv(7'h0a);
      repeat (6) @(posedge ref_clk);
      #1 chk("vec_valid", 24'h0, {23'h0, vec_valid});
      done();
      expv(7'h6e);
      done();
      wr(4'h2, 16'h03ff);
      rd(4'h2, 16'h0000);
      chk("sw_trap_busy", 24'h0, {23'h0, sw_trap_busy});
      $display("test priority done");
      stop_test();
   end
endmodule
`default_nettype wire
